/* src/dct_controller.sv */
// DDR2 command sequencer: takes one request per memory clock, checks the
// timing, drives the command pins, the memory clock and the write strobes.
// Assumes request inputs come from logic on clock_in; CK_DIV is even.
`default_nettype none

module dct_controller #(
  parameter int AL = 0,
  parameter int CL = 5,
  parameter int BL = 4,
  parameter int NWR_RESET = 4,
  parameter int REFRESH_WINDOW_MS = 64
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire dct_pkg::dct_kind_type req_kind_in,
  input wire logic [2:0] req_bank_in,
  input wire logic [12:0] req_addr_in,
  input wire logic req_autopre_in,
  input wire logic odt_in,
  input wire logic halt_in,
  input wire logic [15:0] wdata_in,
  output logic req_accept_out,
  output logic refresh_due_out,
  output logic clock_stopped_out,
  output logic ck_out,
  output var dct_pkg::dct_pins_type pins_out,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_out,
  output logic lower_byte_strobe_out,
  output logic lower_byte_strobe_oe_out,
  output logic upper_byte_strobe_out,
  output logic upper_byte_strobe_oe_out,
  output logic wdata_take_out
);

  localparam int WL = AL + CL - 1;
  localparam int RTP_GAP = (dct_pkg::T_RTP_PS > 2 * dct_pkg::TCK_PS) ? dct_pkg::N_RTP : AL + BL / 2;
  localparam int WR_END = WL + BL / 2 + dct_pkg::N_WR;
  localparam int REFI = dct_pkg::refi_ck(REFRESH_WINDOW_MS, dct_pkg::REFRESH_CMDS);
  localparam logic [5:0] BURST_START = 6'(WL * dct_pkg::CK_DIV);
  localparam logic [5:0] BURST_END = 6'(WL * dct_pkg::CK_DIV + BL);

  typedef dct_pkg::dct_tmr_type tmr_t;
  localparam int NB = dct_pkg::N_BANKS;

  // ==========================================================
  // Memory clock divider
  logic [3:0] div_q;
  logic tick;
  dct_pkg::dct_power_type pw_q, pw_d;

  assign tick = (div_q == 4'(dct_pkg::CK_DIV - 1));

  // Pins change with the falling clock so the device sees them settled at the rise
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      div_q <= '0;
      ck_out <= 1'b0;
    end else begin
      div_q <= tick ? '0 : div_q + 4'h1;
      // Low from the tick on, so the memory clock rises half a period after the pins move
      ck_out <= (pw_d != dct_pkg::PW_STOP) && !tick && (div_q + 4'h1 >= 4'(dct_pkg::CK_DIV / 2));
    end
  end

  // ==========================================================
  // Timers
  logic [NB-1:0] act_ld, pre_ld, rcd_ld, act_zero, pre_zero, rcd_zero;
  tmr_t act_val [NB];
  tmr_t pre_val [NB];
  tmr_t rcd_val [NB];
  tmr_t pre_cnt [NB];
  logic [dct_pkg::FAW_SLOTS-1:0] faw_zero;
  logic [1:0] faw_ptr_q;
  logic rrd_ld, rrd_zero, glob_ld, glob_zero, bus_ld, bus_zero, cke_ld, cke_zero, faw_ld;
  tmr_t glob_val, bus_val;

  for (genvar b = 0; b < NB; b++) begin : g_bank
    dct_countdown #(.W(dct_pkg::TMR_W)) u_act (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
      .load_in(act_ld[b]), .value_in(act_val[b]), .count_out(), .zero_out(act_zero[b]));
    dct_countdown #(.W(dct_pkg::TMR_W)) u_pre (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
      .load_in(pre_ld[b]), .value_in(pre_val[b]), .count_out(pre_cnt[b]), .zero_out(pre_zero[b]));
    dct_countdown #(.W(dct_pkg::TMR_W)) u_rcd (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
      .load_in(rcd_ld[b]), .value_in(rcd_val[b]), .count_out(), .zero_out(rcd_zero[b]));
  end

  // One slot per recent activate; the oldest must have expired
  for (genvar s = 0; s < dct_pkg::FAW_SLOTS; s++) begin : g_faw
    dct_countdown #(.W(dct_pkg::TMR_W)) u_faw (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
      .load_in(faw_ld && faw_ptr_q == 2'(s)), .value_in(tmr_t'(dct_pkg::N_FAW)), .count_out(),
      .zero_out(faw_zero[s]));
  end

  dct_countdown #(.W(dct_pkg::TMR_W)) u_rrd (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
    .load_in(rrd_ld), .value_in(tmr_t'(dct_pkg::N_RRD)), .count_out(), .zero_out(rrd_zero));
  dct_countdown #(.W(dct_pkg::TMR_W)) u_glob (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
    .load_in(glob_ld), .value_in(glob_val), .count_out(), .zero_out(glob_zero));
  dct_countdown #(.W(dct_pkg::TMR_W)) u_bus (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
    .load_in(bus_ld), .value_in(bus_val), .count_out(), .zero_out(bus_zero));
  dct_countdown #(.W(dct_pkg::TMR_W)) u_cke (.clock_in(clock_in), .rst_in(rst_in), .tick_in(tick),
    .load_in(cke_ld), .value_in(tmr_t'(dct_pkg::N_CKE_HOLD)), .count_out(), .zero_out(cke_zero));

  // ==========================================================
  // Legality and timer loads
  logic [NB-1:0] open_q;
  logic [3:0] nwr_q;
  logic legal, go, all_idle;

  always_comb begin
    all_idle = (open_q == '0) && (&act_zero);
    unique case (req_kind_in)
      dct_pkg::K_NOP: legal = 1'b1;
      dct_pkg::K_ACT: legal = !open_q[req_bank_in] && act_zero[req_bank_in] && rrd_zero
                              && faw_zero[faw_ptr_q] && glob_zero;
      dct_pkg::K_READ, dct_pkg::K_WRITE: legal = open_q[req_bank_in] && rcd_zero[req_bank_in]
                                                 && bus_zero && glob_zero;
      // A bank still precharging takes no new single-bank precharge; precharge-all checks only the row-active time of open banks
      dct_pkg::K_PRE: legal = pre_zero[req_bank_in] && act_zero[req_bank_in] && glob_zero;
      dct_pkg::K_PREALL: legal = (&(pre_zero | ~open_q)) && glob_zero;
      dct_pkg::K_REF, dct_pkg::K_MRS: legal = all_idle && glob_zero;
      dct_pkg::K_SRE: legal = all_idle && glob_zero && cke_zero;
      dct_pkg::K_SRX: legal = 1'b1;
      default: legal = 1'b0;
    endcase
    if (req_kind_in == dct_pkg::K_SRX) begin
      go = tick && req_valid_in && pw_q == dct_pkg::PW_SREF && cke_zero;
    end else begin
      go = tick && req_valid_in && legal && pw_q == dct_pkg::PW_RUN && !halt_in;
    end
  end

  always_comb begin
    rrd_ld = go && req_kind_in == dct_pkg::K_ACT;
    faw_ld = rrd_ld;
    bus_ld = go && (req_kind_in == dct_pkg::K_READ || req_kind_in == dct_pkg::K_WRITE);
    // Writes keep the strobe bus until their postamble is over
    bus_val = (req_kind_in == dct_pkg::K_WRITE) ? tmr_t'(WL + BL / 2 + 1) : tmr_t'(BL / 2);
    glob_ld = go && (req_kind_in == dct_pkg::K_REF || req_kind_in == dct_pkg::K_MRS
                     || req_kind_in == dct_pkg::K_SRX);
    unique case (req_kind_in)
      dct_pkg::K_REF: glob_val = tmr_t'(dct_pkg::N_RFC);
      dct_pkg::K_MRS: glob_val = tmr_t'(dct_pkg::MRD_CK);
      default: glob_val = tmr_t'(dct_pkg::N_XSNR);
    endcase
    for (int i = 0; i < NB; i++) begin
      act_ld[i] = 1'b0;
      pre_ld[i] = 1'b0;
      rcd_ld[i] = 1'b0;
      act_val[i] = tmr_t'(dct_pkg::N_RPA);
      pre_val[i] = tmr_t'(dct_pkg::N_RAS);
      rcd_val[i] = tmr_t'(dct_pkg::N_RCD);
      if (go && req_kind_in == dct_pkg::K_PREALL) begin
        act_ld[i] = 1'b1;
      end else if (go && 3'(i) == req_bank_in) begin
        unique case (req_kind_in)
          dct_pkg::K_ACT: begin
            pre_ld[i] = 1'b1;
            rcd_ld[i] = 1'b1;
          end
          dct_pkg::K_PRE: begin
            act_ld[i] = 1'b1;
            act_val[i] = tmr_t'(dct_pkg::N_RP);
          end
          dct_pkg::K_READ: begin
            // Internal precharge waits out the row-active minimum already in pre_cnt
            act_ld[i] = req_autopre_in;
            act_val[i] = dct_pkg::tmr_max(pre_cnt[i], tmr_t'(RTP_GAP)) + tmr_t'(dct_pkg::N_RP);
            pre_ld[i] = !req_autopre_in;
            pre_val[i] = dct_pkg::tmr_max(pre_cnt[i], tmr_t'(RTP_GAP));
          end
          dct_pkg::K_WRITE: begin
            act_ld[i] = req_autopre_in;
            act_val[i] = dct_pkg::tmr_max(pre_cnt[i], tmr_t'(WL + BL / 2) + tmr_t'(nwr_q))
                         + tmr_t'(dct_pkg::N_RP);
            pre_ld[i] = !req_autopre_in;
            pre_val[i] = dct_pkg::tmr_max(pre_cnt[i], tmr_t'(WR_END));
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Bank state and mode shadow
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      open_q <= '0;
      faw_ptr_q <= '0;
      nwr_q <= 4'(NWR_RESET);
    end else if (go) begin
      unique case (req_kind_in)
        dct_pkg::K_ACT: begin
          open_q[req_bank_in] <= 1'b1;
          faw_ptr_q <= faw_ptr_q + 2'h1;
        end
        dct_pkg::K_READ, dct_pkg::K_WRITE: if (req_autopre_in) open_q[req_bank_in] <= 1'b0;
        dct_pkg::K_PRE: open_q[req_bank_in] <= 1'b0;
        dct_pkg::K_PREALL: open_q <= '0;
        // Write recovery field of the base mode register, coded as count minus one
        dct_pkg::K_MRS: if (req_bank_in == 3'h0) nwr_q <= {1'b0, req_addr_in[dct_pkg::NWR_LSB +: 3]} + 4'h1;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Power state and clock enable
  logic cke_d;

  always_comb begin
    pw_d = pw_q;
    if (tick) begin
      unique case (pw_q)
        dct_pkg::PW_RUN: begin
          if (go && req_kind_in == dct_pkg::K_SRE) pw_d = dct_pkg::PW_SREF;
          else if (halt_in && !go && cke_zero) pw_d = dct_pkg::PW_HALT;
        end
        dct_pkg::PW_SREF: if (go) pw_d = dct_pkg::PW_RUN;
        dct_pkg::PW_HALT: begin
          // Clock keeps running until the low enable has been registered
          if (halt_in && cke_zero) pw_d = dct_pkg::PW_STOP;
          else if (!halt_in && cke_zero) pw_d = dct_pkg::PW_RUN;
        end
        dct_pkg::PW_STOP: if (!halt_in) pw_d = dct_pkg::PW_HALT;
      endcase
    end
    cke_d = (pw_d == dct_pkg::PW_RUN);
    cke_ld = tick && ((cke_d != pins_out.cke) || (pw_q == dct_pkg::PW_STOP && pw_d != pw_q));
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pw_q <= dct_pkg::PW_HALT;
      clock_stopped_out <= 1'b0;
    end else begin
      pw_q <= pw_d;
      clock_stopped_out <= (pw_d == dct_pkg::PW_STOP);
    end
  end

  // ==========================================================
  // Command pins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pins_out <= '{cke: 1'b0, cmd: dct_pkg::CMD_DESEL, ba: 3'h0, addr: 13'h0000, odt: 1'b0};
      req_accept_out <= 1'b0;
    end else begin
      req_accept_out <= go;
      if (tick) begin
        pins_out.cke <= cke_d;
        pins_out.odt <= odt_in;
        pins_out.ba <= req_bank_in;
        pins_out.addr <= req_addr_in;
        pins_out.cmd <= cke_d ? dct_pkg::CMD_NOP : dct_pkg::CMD_DESEL;
        if (go) begin
          unique case (req_kind_in)
            dct_pkg::K_ACT: pins_out.cmd <= dct_pkg::CMD_ACT;
            dct_pkg::K_READ: pins_out.cmd <= dct_pkg::CMD_READ;
            dct_pkg::K_WRITE: pins_out.cmd <= dct_pkg::CMD_WRITE;
            dct_pkg::K_PRE, dct_pkg::K_PREALL: pins_out.cmd <= dct_pkg::CMD_PRE;
            dct_pkg::K_REF, dct_pkg::K_SRE: pins_out.cmd <= dct_pkg::CMD_REF;
            dct_pkg::K_MRS: pins_out.cmd <= dct_pkg::CMD_MRS;
            dct_pkg::K_SRX: pins_out.cmd <= dct_pkg::CMD_DESEL;
            default: pins_out.cmd <= dct_pkg::CMD_NOP;
          endcase
          if (req_kind_in == dct_pkg::K_READ || req_kind_in == dct_pkg::K_WRITE) begin
            pins_out.addr[dct_pkg::AUTOPRE_BIT] <= req_autopre_in;
          end else if (req_kind_in == dct_pkg::K_PRE || req_kind_in == dct_pkg::K_PREALL) begin
            pins_out.addr[dct_pkg::AUTOPRE_BIT] <= (req_kind_in == dct_pkg::K_PREALL);
          end
        end
      end
    end
  end

  // ==========================================================
  // Refresh interval
  logic [15:0] refi_q;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      refi_q <= 16'(REFI - 1);
      refresh_due_out <= 1'b0;
    end else if (tick) begin
      refi_q <= (refi_q == 16'h0000) ? 16'(REFI - 1) : refi_q - 16'h0001;
      // A new interval ending in the same tick as a refresh keeps the flag up
      if (refi_q == 16'h0000) refresh_due_out <= 1'b1;
      else if (go && req_kind_in == dct_pkg::K_REF) refresh_due_out <= 1'b0;
    end
  end

  // ==========================================================
  // Write data and strobes, one timing group per byte
  logic wact_q, wact_d, burst_d;
  logic [5:0] wseq_q, wseq_d;
  logic [1:0] strobe_q, strobe_oe_q;

  always_comb begin
    wact_d = wact_q;
    wseq_d = wseq_q;
    if (go && req_kind_in == dct_pkg::K_WRITE) begin
      wact_d = 1'b1;
      wseq_d = 6'h00;
    end else if (wact_q && wseq_q == BURST_END) begin
      wact_d = 1'b0;
    end else if (wact_q) begin
      wseq_d = wseq_q + 6'h01;
    end
    burst_d = wact_d && wseq_d >= BURST_START && wseq_d < BURST_END;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wact_q <= 1'b0;
      wseq_q <= 6'h00;
      strobe_q <= 2'h0;
      strobe_oe_q <= 2'h0;
      dq_out <= 16'h0000;
      dq_oe_out <= 2'h0;
      wdata_take_out <= 1'b0;
    end else begin
      wact_q <= wact_d;
      wseq_q <= wseq_d;
      // Strobes leave high impedance low together with the write command
      strobe_oe_q <= {2{wact_d}};
      strobe_q <= burst_d ? ~strobe_q : 2'h0;
      dq_oe_out <= {2{burst_d}};
      wdata_take_out <= burst_d;
      if (burst_d) dq_out <= wdata_in;
    end
  end

  assign lower_byte_strobe_out = strobe_q[0];
  assign lower_byte_strobe_oe_out = strobe_oe_q[0];
  assign upper_byte_strobe_out = strobe_q[1];
  assign upper_byte_strobe_oe_out = strobe_oe_q[1];

endmodule : dct_controller

`default_nettype wire

/* src/dct_countdown.sv */
// Down counter measuring a spacing in memory clocks.
// Assumes tick_in is a one-cycle pulse once per memory clock.
`default_nettype none

module dct_countdown #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic [W-1:0] count_out,
  output logic zero_out
);

  logic [W-1:0] count_q;

  // Loading N on a tick leaves zero N ticks later, the tick of the load counted
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else if (load_in) begin
      count_q <= (value_in == '0) ? '0 : value_in - 1'b1;
    end else if (tick_in && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign count_out = count_q;
  assign zero_out = (count_q == '0);

endmodule : dct_countdown

`default_nettype wire

/* src/dct_pkg.sv */
// Constants, types and command encodings for the DDR2 command sequencer.
// Assumes a 10 MHz system clock and a memory clock made by dividing it.
`default_nettype none

package dct_pkg;

  // ==========================================================
  // Clocking
  localparam int CLK_PERIOD_PS = 100000;
  localparam int CK_DIV = 2;
  localparam int TCK_PS = CLK_PERIOD_PS * CK_DIV;
  localparam int TMR_W = 8;
  localparam int N_BANKS = 8;
  localparam int FAW_SLOTS = 4;
  typedef logic [TMR_W-1:0] dct_tmr_type;

  // ==========================================================
  // Device minimum times
  localparam int T_RP_PS = 15000;
  localparam int T_RAS_PS = 45000;
  localparam int T_RCD_PS = 15000;
  localparam int T_RRD_PS = 10000;
  localparam int T_FAW_PS = 50000;
  localparam int T_RTP_PS = 7500;
  localparam int T_WR_PS = 15000;
  localparam int T_RFC_PS = 127500;
  localparam int T_XSNR_EXTRA_PS = 10000;
  localparam int T_IS_PS = 200;
  localparam int T_IH_PS = 275;
  localparam int CKE_MIN_CK = 3;
  localparam int MRD_CK = 2;
  localparam int REFRESH_CMDS = 8192;
  localparam int NWR_LSB = 9;
  localparam int AUTOPRE_BIT = 10;

  // Least times round up, never below one clock
  function automatic int ceil_ck(input int ps);
    int n;
    n = (ps + TCK_PS - 1) / TCK_PS;
    return (n < 1) ? 1 : n;
  endfunction : ceil_ck

  // Average refresh spacing is a longest time, so it rounds down
  function automatic int refi_ck(input int ms, input int cmds);
    longint n;
    n = (longint'(ms) * 64'h3B9ACA00) / (longint'(cmds) * longint'(TCK_PS));
    return (n < 1) ? 1 : int'(n);
  endfunction : refi_ck

  function automatic dct_tmr_type tmr_max(input dct_tmr_type a, input dct_tmr_type b);
    return (a > b) ? a : b;
  endfunction : tmr_max

  localparam int N_RP = ceil_ck(T_RP_PS);
  localparam int N_RPA = N_RP + 1;
  localparam int N_RAS = ceil_ck(T_RAS_PS);
  localparam int N_RCD = ceil_ck(T_RCD_PS);
  localparam int N_RRD = ceil_ck(T_RRD_PS);
  localparam int N_FAW = ceil_ck(T_FAW_PS);
  localparam int N_RTP = ceil_ck(T_RTP_PS);
  localparam int N_WR = ceil_ck(T_WR_PS);
  localparam int N_RFC = ceil_ck(T_RFC_PS);
  localparam int N_XSNR = ceil_ck(T_RFC_PS + T_XSNR_EXTRA_PS);
  localparam int N_DELAY = ceil_ck(T_IS_PS + TCK_PS + T_IH_PS);
  localparam int N_CKE_HOLD = (CKE_MIN_CK > N_DELAY) ? CKE_MIN_CK : N_DELAY;

  // ==========================================================
  // Requests, pins and power states
  typedef enum logic [3:0] {
    K_NOP = 4'h0, K_ACT = 4'h1, K_READ = 4'h2, K_WRITE = 4'h3, K_PRE = 4'h4,
    K_PREALL = 4'h5, K_REF = 4'h6, K_MRS = 4'h7, K_SRE = 4'h8, K_SRX = 4'h9
  } dct_kind_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dct_cmd_type;

  localparam dct_cmd_type CMD_MRS = 4'h0;
  localparam dct_cmd_type CMD_REF = 4'h1;
  localparam dct_cmd_type CMD_PRE = 4'h2;
  localparam dct_cmd_type CMD_ACT = 4'h3;
  localparam dct_cmd_type CMD_WRITE = 4'h4;
  localparam dct_cmd_type CMD_READ = 4'h5;
  localparam dct_cmd_type CMD_NOP = 4'h7;
  localparam dct_cmd_type CMD_DESEL = 4'hF;

  typedef struct packed {
    logic cke;
    dct_cmd_type cmd;
    logic [2:0] ba;
    logic [12:0] addr;
    logic odt;
  } dct_pins_type;

  typedef enum logic [1:0] {
    PW_RUN = 2'h0, PW_HALT = 2'h1, PW_STOP = 2'h3, PW_SREF = 2'h2
  } dct_power_type;

endpackage : dct_pkg

`default_nettype wire

/* test/dct_controller_props.sv */
// Port assertions for the DDR2 command sequencer.
// Assumes dct_pkg is compiled first; bound onto every dct_controller.
`default_nettype none

// ========
// Checker
module dct_controller_props (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_accept_out,
  input wire logic refresh_due_out,
  input wire logic clock_stopped_out,
  input wire logic ck_out,
  input wire dct_pkg::dct_pins_type pins_out,
  input wire logic [1:0] dq_oe_out,
  input wire logic lower_byte_strobe_out,
  input wire logic lower_byte_strobe_oe_out,
  input wire logic upper_byte_strobe_out,
  input wire logic wdata_take_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic go;
  assign go = req_accept_out;

  a_preall_gap: assert property (go && pins_out.cmd == dct_pkg::CMD_PRE && pins_out.addr[10] |=> !go [*3])
    else $error("precharge-all followed too soon");
  a_mrs_spacing: assert property (go && pins_out.cmd == dct_pkg::CMD_MRS |=> !go [*3])
    else $error("mode load followed too soon");
  a_mrs_cke_high: assert property (go && pins_out.cmd == dct_pkg::CMD_MRS |-> pins_out.cke
    && $past(pins_out.cke, 2))
    else $error("mode load without enable high");
  a_cke_hold: assert property ($changed(pins_out.cke) |=> $stable(pins_out.cke) [*5])
    else $error("clock enable changed too early");
  a_clock_after_cke: assert property ($fell(pins_out.cke) |-> !clock_stopped_out [*4])
    else $error("clock stopped too soon after enable low");
  a_write_burst: assert property (go && pins_out.cmd == dct_pkg::CMD_WRITE |-> lower_byte_strobe_oe_out &&
    !lower_byte_strobe_out ##8 wdata_take_out [*4] ##1 !wdata_take_out)
    else $error("write strobe or burst misplaced");
  a_byte_groups: assert property (wdata_take_out |-> dq_oe_out == 2'h3
    && lower_byte_strobe_out == upper_byte_strobe_out)
    else $error("byte groups not driven together");
  a_cmd_on_low_ck: assert property (!clock_stopped_out && $changed(pins_out.cmd) |-> !ck_out ##1 ck_out)
    else $error("command changed off the low clock phase");
  a_ref_clears_due: assert property (go && pins_out.cmd == dct_pkg::CMD_REF && pins_out.cke |=> !refresh_due_out)
    else $error("refresh left due flag set");

  c_write: cover property (go && pins_out.cmd == dct_pkg::CMD_WRITE);
  c_preall: cover property (go && pins_out.cmd == dct_pkg::CMD_PRE && pins_out.addr[10]);
  c_stop: cover property ($rose(clock_stopped_out));
endmodule : dct_controller_props

bind dct_controller dct_controller_props u_dct_controller_props (.clock_in, .rst_in, .req_accept_out,
  .refresh_due_out, .clock_stopped_out, .ck_out, .pins_out, .dq_oe_out, .lower_byte_strobe_out,
  .lower_byte_strobe_oe_out, .upper_byte_strobe_out, .wdata_take_out);

`default_nettype wire

/* test/dct_mem.sv */
// Behavioural memory device: decodes commands, captures write bytes.
// Assumes the controller drives every pin; the model never drives back.
`default_nettype none

// ========
// Model
module dct_mem (
  input wire logic ck_in,
  input wire dct_pkg::dct_pins_type pins_in,
  input wire logic [15:0] dq_in,
  input wire logic lstrobe_in,
  input wire logic lstrobe_oe_in,
  input wire logic ustrobe_in,
  input wire logic ustrobe_oe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cke_seen = 1'b0;
  logic in_sref = 1'b0;
  logic [12:0] mode_reg = 13'h0000;
  logic [7:0] lo_byte = 8'h00;
  logic [7:0] hi_byte = 8'h00;
  int n_ref = 0;
  int n_mrs = 0;
  int n_lo = 0;
  int odt_halves = 0;
  logic term_on = 1'b0;

  always @(posedge ck_in) begin
    if (cke_seen && pins_in.cke && pins_in.cmd == dct_pkg::CMD_MRS) begin
      n_mrs++;
      if (pins_in.ba == 3'h0) mode_reg = pins_in.addr;
    end
    if (cke_seen && pins_in.cke && pins_in.cmd == dct_pkg::CMD_REF) n_ref++;
    if (cke_seen && !pins_in.cke && pins_in.cmd == dct_pkg::CMD_REF) in_sref = 1'b1;
    cke_seen = pins_in.cke;
  end

  // Exit must not wait for a clock edge
  always @(posedge pins_in.cke) if (in_sref && pins_in.cmd.cs_n) in_sref = 1'b0;

  // Termination starts turning off five clock halves after a low control is registered
  always @(ck_in) begin
    if (ck_in && pins_in.odt) begin
      term_on = 1'b1;
      odt_halves = 0;
    end else if (term_on && (odt_halves > 0 || (ck_in && !pins_in.odt))) begin
      odt_halves++;
      if (odt_halves == 6) term_on = 1'b0;
    end
  end

  // Sample after the edge so data launched with the strobe has settled
  always @(lstrobe_in) begin
    #1;
    if (lstrobe_oe_in) begin
      lo_byte = dq_in[7:0];
      n_lo++;
    end
  end
  always @(ustrobe_in) begin
    #1;
    if (ustrobe_oe_in) hi_byte = dq_in[15:8];
  end
endmodule : dct_mem

`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the sequencer driving a behavioural memory.
// Assumes package, controller, checker and model are compiled first.
`default_nettype none

// ========
// Bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  dct_pkg::dct_kind_type req_kind_in = dct_pkg::K_NOP;
  logic [2:0] req_bank_in = 3'h0;
  logic [12:0] req_addr_in = 13'h0000;
  logic req_autopre_in = 1'b0;
  logic odt_in = 1'b0;
  logic halt_in = 1'b0;
  logic [15:0] wdata_in = 16'hA55A;
  logic req_accept_out, refresh_due_out, clock_stopped_out, ck_out, wdata_take_out;
  logic lower_byte_strobe_out, lower_byte_strobe_oe_out, upper_byte_strobe_out, upper_byte_strobe_oe_out;
  logic [15:0] dq_out;
  logic [1:0] dq_oe_out;
  dct_pkg::dct_pins_type pins_out;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, t1, t2;

  initial forever #50 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;

  dct_controller u_dct_controller (.clock_in, .rst_in, .req_valid_in, .req_kind_in, .req_bank_in,
    .req_addr_in, .req_autopre_in, .odt_in, .halt_in, .wdata_in, .req_accept_out, .refresh_due_out,
    .clock_stopped_out, .ck_out, .pins_out, .dq_out, .dq_oe_out, .lower_byte_strobe_out,
    .lower_byte_strobe_oe_out, .upper_byte_strobe_out, .upper_byte_strobe_oe_out, .wdata_take_out);
  dct_mem u_dct_mem (.ck_in(ck_out), .pins_in(pins_out), .dq_in(dq_out), .lstrobe_in(lower_byte_strobe_out),
    .lstrobe_oe_in(lower_byte_strobe_oe_out), .ustrobe_in(upper_byte_strobe_out),
    .ustrobe_oe_in(upper_byte_strobe_oe_out));

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #5;
  endtask : step

  // Hold the request until accepted, then one idle cycle before the next
  task automatic issue(input dct_pkg::dct_kind_type k, input logic [2:0] b, input logic [12:0] a,
                       input logic ap, output int t);
    int i;
    i = 0;
    req_kind_in = k;
    req_bank_in = b;
    req_addr_in = a;
    req_autopre_in = ap;
    req_valid_in = 1'b1;
    do begin
      step(1);
      i++;
    end while (req_accept_out !== 1'b1 && i < 400);
    t = cyc;
    req_valid_in = 1'b0;
    if (i >= 400) begin
      n_errors++;
      conclude();
    end
    step(1);
  endtask : issue

  task automatic wait_on(input int w, input logic v);
    int i;
    for (i = 0; i < 2000 && (w == 0 ? pins_out.cke : w == 1 ? refresh_due_out : clock_stopped_out) !== v; i++) step(1);
    if (i >= 2000) begin
      n_errors++;
      conclude();
    end
  endtask : wait_on

  task automatic t_mode();
    issue(dct_pkg::K_NOP, 3'h0, 13'h0000, 1'b0, t0);
    chk(pins_out.cmd, dct_pkg::CMD_NOP);
    issue(dct_pkg::K_MRS, 3'h0, 13'h0600, 1'b0, t1);
    issue(dct_pkg::K_MRS, 3'h1, 13'h0000, 1'b0, t2);
    step(2);
    chk(t2 - t1 >= 4, 1);
    chk(u_dct_mem.mode_reg, 13'h0600);
    chk(u_dct_mem.n_mrs, 2);
  endtask : t_mode

  task automatic t_refresh();
    wait_on(1, 1'b1);
    issue(dct_pkg::K_REF, 3'h0, 13'h0000, 1'b0, t1);
    chk(refresh_due_out, 0);
    issue(dct_pkg::K_REF, 3'h0, 13'h0000, 1'b0, t2);
    step(2);
    chk(u_dct_mem.n_ref, 2);
  endtask : t_refresh

  task automatic t_write();
    odt_in = 1'b1;
    issue(dct_pkg::K_ACT, 3'h1, 13'h0123, 1'b0, t0);
    chk(pins_out.odt, 1);
    issue(dct_pkg::K_WRITE, 3'h1, 13'h0008, 1'b1, t1);
    step(20);
    chk(u_dct_mem.lo_byte, 8'h5A);
    chk(u_dct_mem.hi_byte, 8'hA5);
    chk(u_dct_mem.n_lo, 4);
    // Write latency 4, half burst 2, recovery 4 plus precharge 1, in ticks
    issue(dct_pkg::K_ACT, 3'h1, 13'h0042, 1'b0, t2);
    chk(t2 - t1 >= 22, 1);
    odt_in = 1'b0;
    step(4);
    chk(u_dct_mem.term_on, 1);
    step(4);
    chk(u_dct_mem.term_on, 0);
  endtask : t_write

  task automatic t_read();
    issue(dct_pkg::K_ACT, 3'h3, 13'h0020, 1'b0, t0);
    issue(dct_pkg::K_READ, 3'h3, 13'h0004, 1'b1, t1);
    chk(t1 - t0 <= 4, 1);
    issue(dct_pkg::K_ACT, 3'h3, 13'h0021, 1'b0, t2);
    chk(t2 - t1 >= 6, 1);
    issue(dct_pkg::K_PRE, 3'h3, 13'h0000, 1'b0, t1);
    issue(dct_pkg::K_ACT, 3'h3, 13'h0022, 1'b0, t2);
    chk(t2 - t1 >= 2, 1);
  endtask : t_read

  task automatic t_preall();
    issue(dct_pkg::K_ACT, 3'h2, 13'h0010, 1'b0, t0);
    issue(dct_pkg::K_PREALL, 3'h0, 13'h0400, 1'b0, t1);
    issue(dct_pkg::K_ACT, 3'h2, 13'h0011, 1'b0, t2);
    chk(t2 - t1 >= 4, 1);
    issue(dct_pkg::K_PREALL, 3'h0, 13'h0400, 1'b0, t1);
  endtask : t_preall

  task automatic t_sref_halt();
    issue(dct_pkg::K_SRE, 3'h0, 13'h0000, 1'b0, t1);
    step(4);
    chk(u_dct_mem.in_sref, 1);
    issue(dct_pkg::K_SRX, 3'h0, 13'h0000, 1'b0, t2);
    chk(u_dct_mem.in_sref, 0);
    halt_in = 1'b1;
    wait_on(2, 1'b1);
    chk(u_dct_mem.cke_seen, 0);
    halt_in = 1'b0;
    wait_on(0, 1'b1);
    issue(dct_pkg::K_ACT, 3'h4, 13'h0001, 1'b0, t0);
    chk(clock_stopped_out, 0);
  endtask : t_sref_halt

  initial begin
    step(3);
    rst_in = 1'b0;
    wait_on(0, 1'b1);
    t_mode();
    t_refresh();
    t_write();
    t_read();
    t_preall();
    t_sref_halt();
    conclude();
  end
endmodule : tb_top

`default_nettype wire
